// ---- rtl/xps_host_end.sv ----
// Purpose: Host controller that programs the switch from a command FIFO
// Assumes: One device on the link; link clock made here by a divider
// Notes: FIFO module lives in this file
`timescale 1ns/1ps
`include "xps_consts.svh"

module xps_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 4
) (
    input wire logic mclk,
    input wire logic rst,
    input wire logic [WIDTH-1:0] inData,
    input wire logic inValid,
    output logic inReady,
    output logic [WIDTH-1:0] outData,
    output logic outValid,
    input wire logic outReady
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wrPtr;
    logic [AW-1:0] rdPtr;
    logic [AW:0] count;
    logic doWrite;
    logic doRead;

    // Honest full and empty flags from the fill count
    assign inReady = (count != (AW+1)'(DEPTH));
    assign outValid = (count != '0);
    assign doWrite = inValid & inReady;
    assign doRead = outValid & outReady;
    assign outData = mem[rdPtr];

    // Storage, written by index
    always_ff @(posedge mclk) begin
        if (doWrite) begin
            mem[wrPtr] <= inData;
        end
    end

    // Pointers and count
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            wrPtr <= '0;
            rdPtr <= '0;
            count <= '0;
        end else begin
            wrPtr <= doWrite ? AW'((wrPtr + 1'b1) % DEPTH) : wrPtr;
            rdPtr <= doRead ? AW'((rdPtr + 1'b1) % DEPTH) : rdPtr;
            count <= count + (AW+1)'(doWrite) - (AW+1)'(doRead);
        end
    end
endmodule

module xps_host_end (
    input wire logic mclk,
    input wire logic rst,
    xps_link_if.host link,
    input wire logic [`XPS_WORD_W-1:0] wordData,
    input wire logic wordValid,
    output logic wordReady,
    input wire logic disableAll,
    output logic busy,
    output logic chainEcho
);

    ////////////////////////////////////////////////////////////////////////////
    // Command FIFO

    xps_pkg::xps_word_t headWord;
    logic headValid;
    logic headTake;

    xps_fifo #(.WIDTH(`XPS_WORD_W), .DEPTH(`XPS_FIFO_DEPTH)) xps_fifo_inst (
        .mclk(mclk),
        .rst(rst),
        .inData(wordData),
        .inValid(wordValid),
        .inReady(wordReady),
        .outData(headWord),
        .outValid(headValid),
        .outReady(headTake)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Sequencer

    xps_pkg::xps_host_state_t state;
    xps_pkg::xps_word_t curWord;
    xps_pkg::xps_prog_t fixedProg;
    logic [5:0] bitCnt;
    logic [7:0] timer;
    logic timerDone;
    logic isParallel;
    logic echoMeta;
    logic echoSync;

    // Serial out is a pin: two stages before the sequencer reads it
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            echoMeta <= 1'b0;
            echoSync <= 1'b0;
        end else begin
            echoMeta <= link.chainSerialOut;
            echoSync <= echoMeta;
        end
    end

    // Reserved bit of every group sent as one
    for (genvar k = 0; k < `XPS_OUTPUTS; k++) begin : gFix
        assign fixedProg[k*`XPS_GROUP_W +: `XPS_GROUP_W] = {
            curWord[k*`XPS_GROUP_W + `XPS_EN_POS], 1'b1,
            curWord[k*`XPS_GROUP_W +: `XPS_SEL_W]};
    end

    assign timerDone = (timer == 8'h00);
    assign isParallel = curWord[`XPS_WORD_PAR];
    assign headTake = (state == xps_pkg::HS_IDLE) & headValid;
    assign busy = (state != xps_pkg::HS_IDLE);

    // Link pins, state and timing
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            state <= xps_pkg::HS_IDLE;
            curWord <= '0;
            bitCnt <= 6'h00;
            timer <= 8'h00;
            link.chipEnableN <= 1'b1;
            link.updateN <= 1'b1;
            link.linkClk <= 1'b1;
            link.chainSerialIn <= 1'b0;
            link.loadModeSelect <= 1'b0;
            link.parData <= 4'h0;
            link.outputIndex <= 3'h0;
            link.resetN <= 1'b0;
            chainEcho <= 1'b0;
        end else begin
            link.resetN <= ~disableAll;
            timer <= timerDone ? 8'h00 : timer - 8'h01;
            case (state)
                xps_pkg::HS_IDLE: begin
                    if (headValid) begin
                        curWord <= headWord;
                        link.chipEnableN <= 1'b0;
                        link.loadModeSelect <= headWord[`XPS_WORD_PAR];
                        link.outputIndex <= headWord[`XPS_WORD_IDX_LSB +: 3];
                        link.parData <= headWord[3:0];
                        // Highest output group leads
                        link.chainSerialIn <= headWord[`XPS_PROG_W-1];
                        bitCnt <= 6'(`XPS_PROG_W - 1);
                        timer <= 8'(`XPS_HALF_CYC);
                        state <= xps_pkg::HS_HIGH;
                    end
                end
                xps_pkg::HS_HIGH: begin
                    if (timerDone) begin
                        link.linkClk <= 1'b0;
                        timer <= 8'(`XPS_HALF_CYC);
                        state <= xps_pkg::HS_LOW;
                    end
                end
                xps_pkg::HS_LOW: begin
                    if (timerDone) begin
                        link.linkClk <= 1'b1;
                        timer <= 8'(`XPS_HALF_CYC);
                        chainEcho <= echoSync;
                        if (!isParallel && bitCnt != 6'h00) begin
                            // Whole program every time; update stays high
                            bitCnt <= bitCnt - 6'h01;
                            link.chainSerialIn <= fixedProg[bitCnt - 6'h01];
                            state <= xps_pkg::HS_HIGH;
                        end else begin
                            link.updateN <= 1'b0;
                            timer <= 8'(`XPS_UPD_CYC);
                            state <= xps_pkg::HS_UPD;
                        end
                    end
                end
                xps_pkg::HS_UPD: begin
                    if (timerDone) begin
                        link.updateN <= 1'b1;
                        timer <= 8'(`XPS_HALF_CYC);
                        state <= xps_pkg::HS_DONE;
                    end
                end
                xps_pkg::HS_DONE: begin
                    if (timerDone) begin
                        link.chipEnableN <= 1'b1;
                        state <= xps_pkg::HS_IDLE;
                    end
                end
                default: begin
                    state <= xps_pkg::HS_IDLE;
                end
            endcase
        end
    end

endmodule

// ---- rtl/xps_consts.svh ----
// Purpose: Shared constants of the crosspoint programming link, both ends
// Assumes: 200 MHz mclk, one switch device on the link
// Notes: Behaviour list below, one line each
//
// Behaviour
// - Each output connects one input or none
// - First rank loads, update copies to second
// - Reset clears second rank, first rank kept
// - Serial mode always shifts full program
// - Serial mode selected by driving select low
// - Data clocked only while chip enable low
// - Host holds update high while shifting
// - Second rank transparent while update, enable low
// - Serial data sampled on falling clock, forty bits
// - Five bits per output, position selects output
// - Group order: enable, reserved, select MSB first
// - Reserved bit sent one, forced in parallel
// - Enable zero disables output, ignores select
// - Highest output group shifted first
// - Chain serial out feeds next; last device first
// - Serial out shows register MSB, forty clocks
// - Parallel mode loads addressed group while clock low
// - Reset acts independently, only disables outputs
`ifndef XPS_CONSTS_SVH
`define XPS_CONSTS_SVH

// Program layout
`define XPS_OUTPUTS 8
`define XPS_INPUTS 8
`define XPS_GROUP_W 5
`define XPS_PROG_W 40
`define XPS_EN_POS 4
`define XPS_RES_POS 3
`define XPS_SEL_W 3
`define XPS_CROSS_W 64
`define XPS_SECOND_RESET 40'h00_0000_0000
`define XPS_CROSS_RESET 64'h0000_0000_0000_0000

// Synchroniser: {resetN, ceN, updN, clk, sdata, mode, par[3:0], idx[2:0]}
`define XPS_PIN_W 13
`define XPS_PIN_RESET 13'h1FFF

// Host command word: {parallel, index[2:0], program[39:0]}
`define XPS_WORD_W 44
`define XPS_WORD_PAR 43
`define XPS_WORD_IDX_LSB 40
`define XPS_FIFO_DEPTH 32

// Timing
`define XPS_MCLK_NS 5
`define XPS_HALF_NS 32
`define XPS_HALF_CYC ((`XPS_HALF_NS + `XPS_MCLK_NS - 1) / `XPS_MCLK_NS)
`define XPS_UPD_NS 40
`define XPS_UPD_CYC ((`XPS_UPD_NS + `XPS_MCLK_NS - 1) / `XPS_MCLK_NS)

`endif

// ---- rtl/xps_pkg.sv ----
// Purpose: Types of the crosspoint programming link
// Assumes: Constants come from xps_consts.svh
// Notes: Nothing here is imported; use xps_pkg::name
`include "xps_consts.svh"

package xps_pkg;

    typedef logic [`XPS_PROG_W-1:0] xps_prog_t;
    typedef logic [`XPS_WORD_W-1:0] xps_word_t;
    typedef logic [`XPS_PIN_W-1:0] xps_pins_t;

    // Host sequencer states
    typedef enum logic [2:0] {
        HS_IDLE,
        HS_HIGH,
        HS_LOW,
        HS_UPD,
        HS_DONE
    } xps_host_state_t;

endpackage

// ---- rtl/xps_link_if.sv ----
// Purpose: Programming pins between host controller and switch device
// Assumes: All pins are one-way; active low names end in N
// Notes: No clocking block; both ends sample on their own clock
`timescale 1ns/1ps

interface xps_link_if;
    logic chipEnableN;
    logic updateN;
    logic linkClk;
    logic chainSerialIn;
    logic chainSerialOut;
    logic loadModeSelect;
    logic [3:0] parData;
    logic [2:0] outputIndex;
    logic resetN;

    modport host (
        output chipEnableN,
        output updateN,
        output linkClk,
        output chainSerialIn,
        input chainSerialOut,
        output loadModeSelect,
        output parData,
        output outputIndex,
        output resetN
    );

    modport switch_end (
        input chipEnableN,
        input updateN,
        input linkClk,
        input chainSerialIn,
        output chainSerialOut,
        input loadModeSelect,
        input parData,
        input outputIndex,
        input resetN
    );
endinterface

// ---- rtl/xps_switch_end.sv ----
// Purpose: Programming logic of the eight by eight crosspoint switch
// Assumes: Link pins are asynchronous to mclk and sampled here
// Notes: First rank has no reset so it powers up unknown
`timescale 1ns/1ps
`include "xps_consts.svh"

module xps_switch_end (
    input wire logic mclk,
    input wire logic rst,
    xps_link_if.switch_end link,
    output logic [`XPS_CROSS_W-1:0] crossOn,
    output logic [`XPS_OUTPUTS-1:0] outputOn,
    output logic [`XPS_PROG_W-1:0] activeProgram
);

    ////////////////////////////////////////////////////////////////////////////
    // Pin synchroniser

    xps_pkg::xps_pins_t pinRaw;
    xps_pkg::xps_pins_t pinMeta;
    xps_pkg::xps_pins_t pinSync;

    // Gather every control pin into one vector
    assign pinRaw = {
        link.resetN,
        link.chipEnableN,
        link.updateN,
        link.linkClk,
        link.chainSerialIn,
        link.loadModeSelect,
        link.parData,
        link.outputIndex
    };

    // Two stages; only the second stage is read by logic
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            pinMeta <= `XPS_PIN_RESET;
            pinSync <= `XPS_PIN_RESET;
        end else begin
            pinMeta <= pinRaw;
            pinSync <= pinMeta;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Named views of the synchronised pins

    logic resetNS;
    logic chipEnableNS;
    logic updateNS;
    logic linkClkS;
    logic serialInS;
    logic modeS;
    logic [3:0] parDataS;
    logic [2:0] indexS;

    assign resetNS = pinSync[12];
    assign chipEnableNS = pinSync[11];
    assign updateNS = pinSync[10];
    assign linkClkS = pinSync[9];
    assign serialInS = pinSync[8];
    assign modeS = pinSync[7];
    assign parDataS = pinSync[6:3];
    assign indexS = pinSync[2:0];

    ////////////////////////////////////////////////////////////////////////////
    // Link clock edge detection

    logic linkClkPrev;
    logic fallEdge;

    // Previous sample of the link clock
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            linkClkPrev <= 1'b1;
        end else begin
            linkClkPrev <= linkClkS;
        end
    end

    // One strobe per falling edge of the external clock
    assign fallEdge = linkClkPrev & ~linkClkS;

    ////////////////////////////////////////////////////////////////////////////
    // First rank: forty-bit shift register

    xps_pkg::xps_prog_t shiftReg;
    xps_pkg::xps_prog_t next_shift;
    logic selected;
    logic serialShift;
    logic parallelLoad;
    logic [`XPS_GROUP_W-1:0] parGroup;

    // Chip enable gates every load of the first rank
    assign selected = ~chipEnableNS;
    // Serial mode shifts once per falling edge
    assign serialShift = selected & ~modeS & fallEdge;
    // Parallel mode is level sensitive while the clock is low
    assign parallelLoad = selected & modeS & ~linkClkS;
    // Enable highest, reserved forced high, select below
    assign parGroup = {parDataS[3], 1'b1, parDataS[2:0]};

    // Next value of the first rank
    always_comb begin
        next_shift = shiftReg;
        if (serialShift) begin
            // New bit enters at the bottom; first bit ends at the top
            next_shift = {shiftReg[`XPS_PROG_W-2:0], serialInS};
        end else if (parallelLoad) begin
            for (int k = 0; k < `XPS_OUTPUTS; k++) begin
                if (indexS == 3'(k)) begin
                    next_shift[k*`XPS_GROUP_W +: `XPS_GROUP_W] = parGroup;
                end
            end
        end
    end

    // No reset: contents stay unknown until a program arrives
    always_ff @(posedge mclk) begin
        shiftReg <= next_shift;
    end

    // MSB leaves the device, in either mode
    assign link.chainSerialOut = shiftReg[`XPS_PROG_W-1];

    ////////////////////////////////////////////////////////////////////////////
    // Second rank: transparent update latches

    xps_pkg::xps_prog_t secondRank;
    logic transparent;

    // Open while update and chip enable are both low
    assign transparent = ~updateNS & ~chipEnableNS;

    // Reset pin clears only this rank and wins over update
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            secondRank <= `XPS_SECOND_RESET;
        end else if (!resetNS) begin
            secondRank <= `XPS_SECOND_RESET;
        end else if (transparent) begin
            secondRank <= shiftReg;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Crosspoint decode

    logic [`XPS_CROSS_W-1:0] next_cross;
    logic [`XPS_OUTPUTS-1:0] next_on;

    // One group per output, eight stage enables per group
    for (genvar k = 0; k < `XPS_OUTPUTS; k++) begin : gDecode
        logic groupOn;
        logic [`XPS_SEL_W-1:0] groupSel;

        assign groupOn = secondRank[k*`XPS_GROUP_W + `XPS_EN_POS];
        assign groupSel = secondRank[k*`XPS_GROUP_W +: `XPS_SEL_W];
        assign next_on[k] = groupOn;

        for (genvar j = 0; j < `XPS_INPUTS; j++) begin : gInput
            // At most one stage per output; none when disabled
            assign next_cross[k*`XPS_INPUTS + j] = groupOn & (groupSel == 3'(j));
        end
    end

    // Registered decode drives the analog enables
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            crossOn <= `XPS_CROSS_RESET;
            outputOn <= '0;
            activeProgram <= `XPS_SECOND_RESET;
        end else begin
            crossOn <= next_cross;
            outputOn <= next_on;
            activeProgram <= secondRank;
        end
    end

endmodule

// ---- test/xps_link_monitor.sv ----
// Purpose: Checks the link pins between host and switch ends
// Assumes: One mclk domain, rst active high
// Notes: A shadow register mirrors the serial shifts
`timescale 1ns/1ps

module xps_link_monitor (
    input wire logic mclk,
    input wire logic rst,
    input wire logic chipEnableN,
    input wire logic updateN,
    input wire logic linkClk,
    input wire logic chainSerialIn,
    input wire logic chainSerialOut,
    input wire logic loadModeSelect,
    input wire logic [3:0] parData,
    input wire logic [2:0] outputIndex,
    input wire logic resetN
);
    logic prevClk;
    logic [39:0] shadow;
    logic [5:0] fillCnt;
    logic fallSer;
    logic parLoad;

    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (rst);

    ////////////////////////////////////////////////////////////
    // Serial shift and parallel load events
    assign fallSer = prevClk & ~linkClk & ~chipEnableN & ~loadModeSelect;
    assign parLoad = ~linkClk & ~chipEnableN & loadModeSelect;

    // Count serial bits since the last parallel load
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            prevClk <= 1'h1;
            fillCnt <= 6'h00;
        end else begin
            prevClk <= linkClk;
            if (parLoad) begin
                fillCnt <= 6'h00;
            end else if (fallSer && fillCnt < 6'h28) begin
                fillCnt <= fillCnt + 6'h01;
            end
        end
    end

    // Mirror of the first rank's serial shifts only, not parallel loads, never reset
    always_ff @(posedge mclk) begin
        if (fallSer) begin
            shadow <= {shadow[38:0], chainSerialIn};
        end
    end

    ////////////////////////////////////////////////////////////
    // Pin relations
    mode_hold_a: assert property (!chipEnableN && !$past(chipEnableN) |->
        $stable(loadModeSelect))
        else $error("Mode select moved while enabled");
    shift_upd_a: assert property ($fell(linkClk) && !chipEnableN |-> updateN)
        else $error("Shift with update low");
    upd_width_a: assert property ($fell(updateN) |->
        (!updateN && !chipEnableN && linkClk)[*8])
        else $error("Update strobe too short");
    upd_end_a: assert property ($fell(updateN) |-> ##[8:10] $rose(updateN))
        else $error("Update strobe too long");
    clk_half_a: assert property ($changed(linkClk) |=> $stable(linkClk)[*5])
        else $error("Link clock phase too short");
    clk_idle_a: assert property (chipEnableN |-> linkClk && updateN)
        else $error("Link not idle while disabled");
    data_hold_a: assert property (!linkClk && !chipEnableN |->
        $stable(chainSerialIn) && $stable(parData) && $stable(outputIndex))
        else $error("Data moved while clock low");
    upd_ce_a: assert property (!updateN |-> !chipEnableN)
        else $error("Update low without chip enable");
    echo_msb_a: assert property (fallSer && fillCnt >= 6'h27 |->
        ##[2:6] (chainSerialOut == shadow[39]))
        else $error("Serial out is not register MSB");
    ce_freeze_a: assert property (chipEnableN[*4] |=> $stable(chainSerialOut))
        else $error("Serial out moved while disabled");

    reset_seen_c: cover property (!resetN ##1 resetN);
endmodule

// ---- test/crosspoint_program_control_tb_top.sv ----
// Purpose: Drives the host end and checks the switch end outputs
// Assumes: Inputs change at falling mclk
// Notes: Expected second rank is kept in cur
`timescale 1ns/1ps
`include "xps_consts.svh"

module crosspoint_program_control_tb_top;
    logic mclk;
    logic rst;
    logic [`XPS_WORD_W-1:0] wordData;
    logic wordValid;
    logic disableAll;
    logic wordReady;
    logic busy;
    logic chainEcho;
    logic [`XPS_CROSS_W-1:0] crossOn;
    logic [`XPS_OUTPUTS-1:0] outputOn;
    xps_pkg::xps_prog_t activeProgram;
    xps_pkg::xps_prog_t cur;
    int badCount = 0;
    int nCompared = 0;
    int cycles = 0;
    int accepted;

    xps_link_if xps_link_if_inst ();

    xps_host_end xps_host_end_inst (.mclk(mclk), .rst(rst), .link(xps_link_if_inst.host),
        .wordData(wordData), .wordValid(wordValid), .wordReady(wordReady),
        .disableAll(disableAll), .busy(busy), .chainEcho(chainEcho));

    xps_switch_end xps_switch_end_inst (.mclk(mclk), .rst(rst),
        .link(xps_link_if_inst.switch_end), .crossOn(crossOn), .outputOn(outputOn),
        .activeProgram(activeProgram));

    xps_link_monitor xps_link_monitor_inst (.mclk(mclk), .rst(rst),
        .chipEnableN(xps_link_if_inst.chipEnableN), .updateN(xps_link_if_inst.updateN),
        .linkClk(xps_link_if_inst.linkClk), .chainSerialIn(xps_link_if_inst.chainSerialIn),
        .chainSerialOut(xps_link_if_inst.chainSerialOut),
        .loadModeSelect(xps_link_if_inst.loadModeSelect),
        .parData(xps_link_if_inst.parData), .outputIndex(xps_link_if_inst.outputIndex),
        .resetN(xps_link_if_inst.resetN));

    ////////////////////////////////////////////////////////////
    // Clock and hang guard
    initial begin
        mclk = 1'h0;
        forever #2.5 mclk = ~mclk;
    end

    always @(posedge mclk) begin
        cycles++;
        if (cycles == 20000) begin
            badCount++;
            $display("BAD %0t run timed out", $time);
            wrapUp();
        end
    end

    ////////////////////////////////////////////////////////////
    // Expected outputs from a program
    function automatic logic [63:0] crossOf(input xps_pkg::xps_prog_t p);
        logic [63:0] x;
        x = 64'h0;
        for (int k = 0; k < 8; k++) begin
            if (p[5*k+4] === 1'h1) begin
                x[8*k + int'(p[5*k +: 3])] = 1'h1;
            end
        end
        return x;
    endfunction

    function automatic logic [7:0] onOf(input xps_pkg::xps_prog_t p);
        logic [7:0] o;
        for (int k = 0; k < 8; k++) begin
            o[k] = p[5*k+4];
        end
        return o;
    endfunction

    // Group k is {enable, reserved one, source}
    function automatic xps_pkg::xps_prog_t mkProg(input logic [7:0] ena, input logic up);
        xps_pkg::xps_prog_t p;
        for (int k = 0; k < 8; k++) begin
            p[5*k +: 5] = {ena[k], 1'h1, up ? 3'(k) : 3'(7 - k)};
        end
        return p;
    endfunction

    ////////////////////////////////////////////////////////////
    // Compares and verdict
    task automatic checkVec(input logic [63:0] got, input logic [63:0] exp, input string what);
        nCompared++;
        if (got !== exp) begin
            badCount++;
            $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    task automatic checkBit(input logic got, input logic exp, input string what);
        nCompared++;
        if (got !== exp) begin
            badCount++;
            $display("BAD %0t %s got %b exp %b", $time, what, got, exp);
        end
    endtask

    task automatic checkState(input xps_pkg::xps_prog_t p);
        checkVec(crossOn, crossOf(p), "cross");
        checkVec(64'(outputOn), 64'(onOf(p)), "enable");
        checkVec(64'(activeProgram), 64'(p), "program");
    endtask

    task automatic wrapUp();
        $display("Compared %0d, mismatches %0d", nCompared, badCount);
        if (badCount == 0 && nCompared > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////
    // Host word port drivers
    task automatic push(input xps_pkg::xps_word_t w);
        int n;
        n = 0;
        @(negedge mclk);
        wordData = w;
        wordValid = 1'h1;
        while (wordReady !== 1'h1 && n < 4000) begin
            @(negedge mclk);
            n++;
        end
        if (n >= 4000) begin
            badCount++;
            $display("BAD %0t word never taken", $time);
        end
        @(negedge mclk);
        wordValid = 1'h0;
    endtask

    task automatic waitDone();
        int quiet;
        int n;
        quiet = 0;
        n = 0;
        while (quiet < 8 && n < 6000) begin
            @(negedge mclk);
            n++;
            quiet = (busy === 1'h0) ? quiet + 1 : 0;
        end
        if (quiet < 8) begin
            badCount++;
            $display("BAD %0t host never went idle", $time);
        end
    endtask

    // Serial program: outputs hold until the update strobe
    task automatic sendSer(input xps_pkg::xps_prog_t p);
        push({1'h0, 3'h0, p});
        repeat (300) @(negedge mclk);
        checkState(cur);
        waitDone();
        cur = p;
        checkState(cur);
        checkBit(chainEcho, p[39], "echo");
    endtask

    task automatic sendPar(input int i, input logic [3:0] d);
        push({1'h1, 3'(i), 36'h0, d});
        waitDone();
        cur[5*i +: 5] = {d[3], 1'h1, d[2:0]};
        checkBit(chainEcho, cur[39], "echo");
    endtask

    ////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        rst = 1'h1;
        wordData = 44'h0;
        wordValid = 1'h0;
        disableAll = 1'h0;
        cur = 40'h0;
        repeat (16) @(posedge mclk);
        @(negedge mclk);
        rst = 1'h0;
        repeat (4) @(negedge mclk);
        checkState(cur);
        sendSer(mkProg(8'hF7, 1'h0));
        sendPar(5, 4'hA);
        checkState(cur);
        sendPar(0, 4'h3);
        checkState(cur);
        sendPar(7, 4'hF);
        checkState(cur);
        // Reset pin clears second rank only
        disableAll = 1'h1;
        repeat (10) @(negedge mclk);
        checkState(40'h0);
        disableAll = 1'h0;
        repeat (10) @(negedge mclk);
        checkState(40'h0);
        sendPar(2, 4'h9);
        checkState(cur);
        sendSer(mkProg(8'h7E, 1'h1));
        // Fill the word buffer until it refuses
        @(negedge mclk);
        accepted = 0;
        wordValid = 1'h1;
        wordData = {1'h1, 3'h4, 36'h0, 4'h8};
        while (wordReady === 1'h1 && accepted < 40) begin
            @(negedge mclk);
            accepted++;
            wordData = {1'h1, 3'h4, 36'h0, 4'h8 | 4'(accepted % 8)};
        end
        wordValid = 1'h0;
        checkBit(accepted >= 32 && accepted <= 33, 1'h1, "fill");
        waitDone();
        cur[20 +: 5] = {1'h1, 1'h1, 3'((accepted - 1) % 8)};
        checkState(cur);
        wrapUp();
    end
endmodule
